// ---- rtl/xmb_defines.svh ----
`ifndef XMB_DEFINES_SVH
`define XMB_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define XMB_IDX_CCS        8'h8E
`define XMB_IDX_CTRL       8'h90
`define XMB_IDX_GPIO       8'h91
`define XMB_IDX_STAT       8'h92
`define XMB_IDX_PTR0       8'h93
`define XMB_IDX_PTR1       8'h94

// ----------------------------------------
// Field positions, reset values and write masks
// ----------------------------------------
`define XMB_CK_TDIV4       3
`define XMB_CT_LOW_EXT     0
`define XMB_CT_HIGH_EXT    1
`define XMB_CT_ALE_LVL     2
`define XMB_CT_PSEL        3
`define XMB_CCS_RST        8'h01
`define XMB_CCS_MASK       8'h0F
`define XMB_CTRL_RST       8'h03
`define XMB_CTRL_MASK      8'h0F

// ----------------------------------------
// Timing counts in oscillator clocks, and the reset vector
// ----------------------------------------
`define XMB_CYC_CLKS       6'h04
`define XMB_TMR_DIV_STD    4'hC
`define XMB_TMR_DIV_FAST   4'h4
`define XMB_SKIP_T         6'h04
`define XMB_FETCH_END      6'h05
`define XMB_RESET_VECTOR   16'h0000

`endif

// ---- rtl/xmb_pkg.sv ----
package xmb_pkg;
  `include "xmb_defines.svh"

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_MOVE} xmb_state_e;
  typedef enum logic [1:0] {PM_USER, PM_PARALLEL, PM_SERIAL} xmb_prog_e;

  // Whole data move length in clocks: (code + 2) instruction cycles
  function automatic logic [5:0] xmb_move_clks(input logic [2:0] code);
    xmb_move_clks = 6'({3'h0, code} + 6'h02) * `XMB_CYC_CLKS;
  endfunction

  // Read or write strobe width in clocks
  function automatic logic [5:0] xmb_strobe_w(input logic [2:0] code);
    xmb_strobe_w = (code == 3'h0) ? 6'h02 : 6'({3'h0, code} * 6'h04);
  endfunction

  function automatic logic xmb_addr_ok(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    xmb_addr_ok = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) &&
                  ((idx == `XMB_IDX_CCS) || ((idx >= `XMB_IDX_CTRL) &&
                   (idx <= `XMB_IDX_PTR1)));
  endfunction

  function automatic logic [31:0] xmb_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    for (int i = 0; i < 4; i++)
    begin
      xmb_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction
endpackage

// ---- rtl/xmb_sync2.sv ----
`timescale 1ns/10ps
module xmb_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;

  always_ff @(posedge clock)
  begin
    stage1 <= d;
    q      <= stage1;
  end
endmodule

// ---- rtl/xmb_axil_slave.sv ----
`timescale 1ns/10ps
module xmb_axil_slave
  import xmb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             reg_wr,
  output logic [11:0]      reg_waddr,
  output logic [31:0]      reg_wdata,
  output logic [3:0]       reg_wstrb,
  input  wire logic [31:0] reg_rdata
);
  logic aw_full, w_full;
  logic next_aw_full, next_w_full, next_bvalid, next_rvalid;
  logic next_awready, next_wready, next_arready;
  logic [11:0] next_waddr;
  logic [31:0] next_wdata, next_rdata;
  logic [3:0]  next_wstrb;
  logic [1:0]  next_bresp, next_rresp;

  always_comb
  begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_waddr   = reg_waddr;
    next_wdata   = reg_wdata;
    next_wstrb   = reg_wstrb;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    reg_wr       = aw_full && w_full && !s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_full = 1'b1;
      next_waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_full = 1'b1;
      next_wdata  = s_axi_wdata;
      next_wstrb  = s_axi_wstrb;
    end
    if (reg_wr)
    begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = xmb_addr_ok(reg_waddr) ? 2'h0 : 2'h2;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata  = xmb_addr_ok(s_axi_araddr) ? reg_rdata : 32'h0;
      next_rresp  = xmb_addr_ok(s_axi_araddr) ? 2'h0 : 2'h2;
    end
    // Ready is registered; it drops while a held beat or a response waits
    next_awready = !next_aw_full && !next_bvalid && !(reg_wr && aw_full);
    next_wready  = !next_w_full && !next_bvalid && !(reg_wr && w_full);
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      reg_waddr     <= 12'h000;
      reg_wdata     <= 32'h0;
      reg_wstrb     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      reg_waddr     <= next_waddr;
      reg_wdata     <= next_wdata;
      reg_wstrb     <= next_wstrb;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_arready <= next_arready;
    end
  end
endmodule

// ---- rtl/xmb_bus_if.sv ----
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
module xmb_bus_if
  import xmb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        req_valid,
  input  wire logic        req_move,
  input  wire logic        req_write,
  input  wire logic [7:0]  req_wdata,
  output logic             req_done,
  output logic [7:0]       rsp_data,
  output logic             timer_tick,
  output logic             addr_latch_strobe_o,
  output logic             addr_latch_strobe_oe,
  input  wire logic        addr_latch_strobe_i,
  output logic             program_store_strobe_n_o,
  output logic             program_store_strobe_n_oe,
  input  wire logic        program_store_strobe_n_i,
  input  wire logic        external_fetch_select_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic [7:0]       low_addr_data_lines_o,
  output logic [7:0]       low_addr_data_lines_oe,
  input  wire logic [7:0]  low_addr_data_lines_i,
  output logic [7:0]       high_addr_lines_o,
  output logic [7:0]       high_addr_lines_oe
);
  // ----------------------------------------
  // Pin synchronisers and register slave
  // ----------------------------------------
  logic [7:0]  lad_s;
  logic        ale_s, pss_s, efs_s;
  logic        reg_wr;
  logic [11:0] reg_waddr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0]  reg_wstrb;

  xmb_sync2 #(.W(11)) u_sync (
    .clock (clock),
    .d     ({low_addr_data_lines_i, addr_latch_strobe_i, program_store_strobe_n_i,
             external_fetch_select_n}),
    .q     ({lad_s, ale_s, pss_s, efs_s})
  );

  xmb_axil_slave u_axil (
    .clock         (clock),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .reg_wr        (reg_wr),
    .reg_waddr     (reg_waddr),
    .reg_wdata     (reg_wdata),
    .reg_wstrb     (reg_wstrb),
    .reg_rdata     (reg_rdata)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  xmb_state_e  state, next_state;
  xmb_prog_e   prog_mode, next_prog_mode;
  logic [1:0]  ph, next_ph;
  logic [5:0]  t, next_t;
  logic [2:0]  move_code, next_move_code;
  logic        move_wr, next_move_wr;
  logic [15:0] move_addr, next_move_addr;
  logic [7:0]  move_wdata, next_move_wdata;
  logic [15:0] fetch_pc, next_fetch_pc;
  logic [3:0]  tdiv, next_tdiv;
  logic [7:0]  clock_control_stretch, next_ccs;
  logic [7:0]  ctrl, next_ctrl;
  logic [31:0] gpio, next_gpio;
  logic [15:0] block_move_pointer [2];
  logic [15:0] next_ptr [2];
  logic        rst_q, fetch_ext, next_fetch_ext;
  logic        next_ale, next_program_store_strobe, next_rd, next_wr, next_done, next_tick;
  logic [7:0]  next_lad, next_lad_oe, next_hal, next_hal_oe, next_rsp;
  logic        low_ext, high_ext, busy, start;
  logic [5:0]  w_len, t_len;

  assign low_ext  = ctrl[`XMB_CT_LOW_EXT];
  assign high_ext = ctrl[`XMB_CT_HIGH_EXT];
  assign busy     = (state != ST_IDLE);
  assign w_len    = xmb_strobe_w(move_code);
  assign t_len    = xmb_move_clks(move_code);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_state      = state;
    next_t          = t + 6'h01;
    next_ph         = ph + 2'h1;
    next_move_code  = move_code;
    next_move_wr    = move_wr;
    next_move_addr  = move_addr;
    next_move_wdata = move_wdata;
    next_fetch_pc   = fetch_pc;
    next_done       = 1'b0;
    next_rsp        = rsp_data;
    next_ccs        = clock_control_stretch;
    next_ctrl       = ctrl;
    next_gpio       = gpio;
    next_ptr        = block_move_pointer;
    start           = 1'b0;
    // Requests start only on the last phase so every access opens a cycle
    unique case (state)
      ST_IDLE:
      begin
        next_t = 6'h00;
        if (ph == 2'h3 && req_valid && low_ext && (req_move || fetch_ext))
        begin
          start          = 1'b1;
          next_move_code = clock_control_stretch[2:0];
          next_move_wr   = req_move && req_write;
          next_move_wdata = req_wdata;
          if (req_move)
          begin
            next_state     = ST_MOVE;
            next_move_addr = block_move_pointer[ctrl[`XMB_CT_PSEL]];
          end
          else
          begin
            next_state     = ST_FETCH;
            next_move_addr = fetch_pc;
            next_fetch_pc  = fetch_pc + 16'h0001;
          end
        end
      end
      ST_FETCH:
      begin
        if (t == `XMB_FETCH_END)
        begin
          next_rsp   = lad_s;
          next_done  = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_MOVE:
      begin
        if (!move_wr && t == w_len + 6'h05)
          next_rsp = lad_s;
        if (t == t_len - 6'h01)
        begin
          next_done  = 1'b1;
          next_state = ST_IDLE;
        end
      end
    endcase
    // Pins; addr/data split across two ports gives the 16-bit bus
    next_ale = low_ext ? (ph == 2'h0 && !(state == ST_MOVE && t == `XMB_SKIP_T))
                       : ctrl[`XMB_CT_ALE_LVL];
    next_program_store_strobe = !(low_ext && state == ST_FETCH && t >= 6'h01 && t <= 6'h03);
    next_rd = !(state == ST_MOVE && !move_wr && t >= `XMB_SKIP_T &&
                t < `XMB_SKIP_T + w_len);
    next_wr = !(state == ST_MOVE && move_wr && t >= `XMB_SKIP_T &&
                t < `XMB_SKIP_T + w_len);
    next_lad    = gpio[7:0];
    next_lad_oe = gpio[23:16];
    if (low_ext)
    begin
      next_lad    = (busy && t < 6'h02) ? move_addr[7:0] : move_wdata;
      next_lad_oe = (busy && t < 6'h02) || (state == ST_MOVE && move_wr &&
                    t < t_len - 6'h01) ? 8'hFF : 8'h00;
    end
    next_hal    = high_ext ? (busy ? move_addr[15:8] : high_addr_lines_o) : gpio[15:8];
    next_hal_oe = high_ext ? 8'hFF : gpio[31:24];
    // Timer prescaler; clock itself is the undivided oscillator
    next_tick = 1'b0;
    next_tdiv = tdiv + 4'h1;
    // At or past the end, so a switch to the short divide never wraps the counter
    if (tdiv >= (clock_control_stretch[`XMB_CK_TDIV4] ? `XMB_TMR_DIV_FAST
                                                        : `XMB_TMR_DIV_STD) - 4'h1)
    begin
      next_tdiv = 4'h0;
      next_tick = 1'b1;
    end
    if (reg_wr && xmb_addr_ok(reg_waddr))
    begin
      unique case (reg_waddr[9:2])
        `XMB_IDX_CCS:
          next_ccs = 8'(xmb_merge({24'h0, clock_control_stretch}, reg_wdata, reg_wstrb))
                     & `XMB_CCS_MASK;
        `XMB_IDX_CTRL:
          next_ctrl = 8'(xmb_merge({24'h0, ctrl}, reg_wdata, reg_wstrb)) & `XMB_CTRL_MASK;
        `XMB_IDX_GPIO: next_gpio = xmb_merge(gpio, reg_wdata, reg_wstrb);
        `XMB_IDX_PTR0:
          next_ptr[0] = 16'(xmb_merge({16'h0, block_move_pointer[0]}, reg_wdata, reg_wstrb));
        `XMB_IDX_PTR1:
          next_ptr[1] = 16'(xmb_merge({16'h0, block_move_pointer[1]}, reg_wdata, reg_wstrb));
        default: ;
      endcase
    end
  end

  // Read mux; the slave answers unmapped addresses itself
  always_comb
  begin
    unique case (s_axi_araddr[9:2])
      `XMB_IDX_CCS:   reg_rdata = {24'h0, clock_control_stretch};
      `XMB_IDX_CTRL:  reg_rdata = {24'h0, ctrl};
      `XMB_IDX_GPIO:  reg_rdata = gpio;
      `XMB_IDX_STAT:  reg_rdata = {20'h0, low_addr_data_lines_i_seen(lad_s), busy,
                                   fetch_ext, prog_mode};
      `XMB_IDX_PTR0:  reg_rdata = {16'h0, block_move_pointer[0]};
      `XMB_IDX_PTR1:  reg_rdata = {16'h0, block_move_pointer[1]};
      default:        reg_rdata = 32'h0;
    endcase
  end

  function automatic logic [7:0] low_addr_data_lines_i_seen(input logic [7:0] v);
    low_addr_data_lines_i_seen = v;
  endfunction

  // Straps: the mode must survive reset, so these flops carry no reset
  always_comb
  begin
    next_prog_mode = prog_mode;
    next_fetch_ext = fetch_ext;
    if (rst_q && !rst)
    begin
      next_fetch_ext = !efs_s;
      if (!ale_s && pss_s)
        next_prog_mode = PM_PARALLEL;
      else if (ale_s && !pss_s)
        next_prog_mode = PM_SERIAL;
      else
        next_prog_mode = PM_USER;
    end
  end

  always_ff @(posedge clock)
  begin
    rst_q     <= rst;
    prog_mode <= next_prog_mode;
    fetch_ext <= next_fetch_ext;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      ph <= 2'h0;
      t <= 6'h00;
      move_code <= 3'h0;
      move_wr <= 1'b0;
      move_addr <= 16'h0000;
      move_wdata <= 8'h00;
      fetch_pc <= `XMB_RESET_VECTOR;
      tdiv <= 4'h0;
      clock_control_stretch <= `XMB_CCS_RST;
      ctrl <= `XMB_CTRL_RST;
      gpio <= 32'h0;
      block_move_pointer <= '{16'h0000, 16'h0000};
      req_done <= 1'b0;
      rsp_data <= 8'h00;
      timer_tick <= 1'b0;
      // Strap pins released while reset is high so they can be read
      addr_latch_strobe_o <= 1'b0;
      addr_latch_strobe_oe <= 1'b0;
      program_store_strobe_n_o <= 1'b1;
      program_store_strobe_n_oe <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      low_addr_data_lines_o <= 8'h00;
      low_addr_data_lines_oe <= 8'h00;
      high_addr_lines_o <= 8'h00;
      high_addr_lines_oe <= 8'h00;
    end
    else
    begin
      state <= next_state;
      ph <= next_ph;
      t <= next_t;
      move_code <= next_move_code;
      move_wr <= next_move_wr;
      move_addr <= next_move_addr;
      move_wdata <= next_move_wdata;
      fetch_pc <= next_fetch_pc;
      tdiv <= next_tdiv;
      clock_control_stretch <= next_ccs;
      ctrl <= next_ctrl;
      gpio <= next_gpio;
      block_move_pointer <= next_ptr;
      req_done <= next_done;
      rsp_data <= next_rsp;
      timer_tick <= next_tick;
      addr_latch_strobe_o <= next_ale;
      addr_latch_strobe_oe <= 1'b1;
      program_store_strobe_n_o <= next_program_store_strobe;
      program_store_strobe_n_oe <= 1'b1;
      rd_n <= next_rd;
      wr_n <= next_wr;
      low_addr_data_lines_o <= next_lad;
      low_addr_data_lines_oe <= next_lad_oe;
      high_addr_lines_o <= next_hal;
      high_addr_lines_oe <= next_hal_oe;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic [5:0] stb_len;
  always_ff @(posedge clock)
    stb_len <= (rst || (rd_n && wr_n)) ? 6'h00 : stb_len + 6'h01;

  sequence s_start;
    start && req_move;
  endsequence
  sequence s_addr_out;
    addr_latch_strobe_o && low_addr_data_lines_oe == 8'hFF;
  endsequence

  AST_ALE_RATE: assert property (low_ext && !busy && addr_latch_strobe_o |=>
    !addr_latch_strobe_o [*3]) else $error("latch strobe not one in four");
  AST_ALE_SKIP: assert property (state == ST_MOVE && t == 6'h04 |=>
    !addr_latch_strobe_o) else $error("latch strobe not skipped in data move");
  AST_ADDR_LATCH: assert property (s_start |=> ##1 s_addr_out and
    (low_addr_data_lines_o == $past(move_addr[7:0]))) else $error("low address missing");
  // Mode is unknown before the first reset fall, so checking starts after it
  AST_STRAP_HOLD: assert property (!rst_q |=> $stable(prog_mode))
    else $error("program mode changed outside reset fall");
  AST_ALE_FORCE: assert property (!low_ext && $stable(ctrl) |=>
    addr_latch_strobe_o == $past(ctrl[`XMB_CT_ALE_LVL])) else $error("latch level wrong");
  AST_MOVE_LEN: assert property (state == ST_MOVE && next_state == ST_IDLE |->
    t == xmb_move_clks(move_code) - 6'h01) else $error("data move length wrong");
  AST_STB_WIDTH: assert property ($past(!rd_n || !wr_n) && rd_n && wr_n |->
    stb_len == xmb_strobe_w(move_code)) else $error("strobe width wrong");
  AST_STB_MUTEX: assert property (rd_n || wr_n)
    else $error("read and write strobes both active");
  AST_TICK: assert property (timer_tick && !clock_control_stretch[`XMB_CK_TDIV4] &&
    $stable(clock_control_stretch) |=> !timer_tick [*8]) else $error("timer tick early");
endmodule

// ---- bench/xmb_mem_model.sv ----
`timescale 1ns/10ps
module xmb_mem_model (
  input  wire logic       clock,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       ps_n,
  input  wire logic [7:0] ad,
  output logic      [7:0] q
);
  logic [7:0] lat;
  logic [7:0] pat;

  initial pat = 8'h55;
  // Low address byte captured by the latch strobe
  always @(negedge ale) lat <= ad;
  // Released bus never holds the last value: the pattern flips every clock
  always @(posedge clock) pat <= ~pat;
  assign q = (!rd_n || !ps_n) ? (lat ^ 8'h5A) : pat;
endmodule

// ---- bench/xmb_bus_if_tb_top.sv ----
`timescale 1ns/10ps
module xmb_bus_if_tb_top;
  logic        clock, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, req_done, req_valid, req_move, req_write, timer_tick;
  logic        rd_n, wr_n, ale_o, ale_oe, ps_o, ps_oe;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  req_wdata, rsp_data, ad_o, ad_oe, ad_mem, hi_o;
  wire  [7:0]  ad_pin = (ad_oe & ad_o) | (~ad_oe & ad_mem);
  int          error_cnt = 0, tests_run = 0, n, k;
  logic        alp = 1'b1, psp = 1'b1, efn = 1'b1;

  xmb_bus_if i_dut (
    .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_move, .req_write,
    .req_wdata, .req_done, .rsp_data, .timer_tick, .addr_latch_strobe_o(ale_o),
    .addr_latch_strobe_oe(ale_oe), .addr_latch_strobe_i(ale_oe ? ale_o : alp),
    .program_store_strobe_n_o(ps_o), .program_store_strobe_n_oe(ps_oe),
    .program_store_strobe_n_i(ps_oe ? ps_o : psp),
    .external_fetch_select_n(efn), .rd_n, .wr_n, .low_addr_data_lines_o(ad_o),
    .low_addr_data_lines_oe(ad_oe), .low_addr_data_lines_i(ad_pin),
    .high_addr_lines_o(hi_o), .high_addr_lines_oe());
  xmb_mem_model i_mem (.clock, .ale(ale_o), .rd_n, .ps_n(ps_oe ? ps_o : 1'b1),
    .ad(ad_pin), .q(ad_mem));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask

  // Reset with given strap levels, then read back the latched mode
  task automatic boot(input logic a, input logic p, input logic e, input logic [2:0] x);
    {alp, psp, efn} <= {a, p, e};
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    rd(12'h248);
    chk(d[2:0] === x, "strap mode");
  endtask

  // One data move; the 48-clock window always spans the whole move
  task automatic mv(input logic [2:0] c, input logic w);
    int lo, al, nd;
    {lo, al, nd} = '0;
    wr(12'h238, {29'h0, c});
    {req_valid, req_move, req_write, req_wdata} <= {2'h3, w, 8'hC3};
    repeat (48)
    begin
      @(posedge clock);
      al += ale_o;
      if (req_done) req_valid <= 1'b0;
      nd += req_done;
      if (req_done && c < 3'h2) chk(rsp_data === 8'h6E, "read data");
      if (!rd_n || !wr_n) lo++;
      if (!rd_n || !wr_n) chk(hi_o === 8'h12 && (w ? rd_n && ad_o === 8'hC3 : wr_n), "strobe");
    end
    chk(lo === (c == 3'h0 ? 2 : 4 * c), "strobe width");
    chk(al === 11 && nd === 1, "latch skip");
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge clock);
    error_cnt++;
    summarize();
  end

  initial
  begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {req_valid, req_move, req_write, req_wdata, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    rd(12'h238);
    chk(d === 32'h1 && r === 2'h0, "stretch reset");
    rd(12'h248);
    chk(d[2:0] === 3'h0, "straps");
    rd(12'h000);
    chk(r === 2'h2, "unmapped");
    n = 0;
    repeat (40) @(posedge clock) n += ale_o;
    chk(n === 10, "latch rate");
    for (k = 0; k < 2; k++)
    begin
      wr(12'h238, k ? 32'h9 : 32'h1);
      n = 0;
      repeat (48) @(posedge clock) n += timer_tick;
      chk(n === (k ? 12 : 4), "timer rate");
    end
    wr(12'h24C, 32'h1234);
    for (k = 0; k < 8; k++) mv(k[2:0], k[1]);
    wr(12'h244, 32'h00A5003C);
    for (k = 0; k < 2; k++)
    begin
      wr(12'h240, k ? 32'h2 : 32'h6);
      repeat (8) @(posedge clock) chk(ale_oe === 1'b1 && ale_o === !k, "latch level");
      chk(ad_o === 8'h3C && ad_oe === 8'hA5, "port io");
    end
    boot(1'b0, 1'b1, 1'b1, 3'h1);
    boot(1'b1, 1'b0, 1'b1, 3'h2);
    boot(1'b1, 1'b1, 1'b0, 3'h4);
    {req_valid, req_move, req_write} <= 3'h4;
    n = 0;
    k = 0;
    do
    begin
      @(posedge clock);
      n++;
      k += !ps_o;
    end
    while (!req_done && n < 40);
    req_valid <= 1'b0;
    chk(req_done === 1'b1 && rsp_data === 8'h5A && k === 3, "fetch");
    summarize();
  end
endmodule
